// ### design/bssu_unit.sv
/*
  Bit scan, select, bit set and shift datapath for a 32-bit core.
  Assumes operands come from the core decoder on the core clock; results are
  registered one cycle after issue together with condition code and overflow.
  Unknown operation codes complete with o_done but raise no write enable.
*/
// Function
// - Nonzero source: highest one-bit index to destination, condition code 010.
// - Zero source: destination all ones, condition code 000.
// - Byte scan: any equal lane pair gives 010 else 000; no write.
// - Select second source if mask and code zero, or mask AND code nonzero.
// - Masks: unordered 000 through ordered 111.
// - Bit set: copy source with bit (position mod 32) forced one.
// - Shift counts above 32 act as 32; bits beyond word discarded.
// - Logical shifts fill zeros; count 32 or more gives zero.
// - Arithmetic left stops before overflow; sets sticky flag or raises fault.
// - Arithmetic right replicates original bit 31 into vacated positions.
// - Dividing right adds one when negative and lost bits nonzero.
// - Source with a zero: highest zero-bit index to destination, code 010.
// - All-ones source: destination all ones, condition code 000.
module bssu_unit (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_issue,
  input wire logic [3:0] i_op,
  input wire logic [31:0] i_src1,
  input wire logic [31:0] i_src2,
  input wire logic [2:0] i_sel_mask,
  input wire logic [2:0] i_condition_code_field,
  input wire logic i_overflow_mask_flag,
  input wire logic i_overflow_sticky_flag,
  output logic o_done,
  output logic [31:0] o_dst,
  output logic o_dst_we,
  output logic [2:0] o_condition_code_field,
  output logic o_cc_we,
  output logic o_overflow_sticky_flag,
  output logic o_overflow_fault
);

  // ---------------------------------------------------------------
  // Scans
  // ---------------------------------------------------------------
  wire logic scan_found;
  wire logic [4:0] scan_idx;
  wire logic span_found;
  wire logic [4:0] span_idx;
  wire logic [31:0] inv_src1;
  // Clear-bit span is a set-bit scan of the inverted word
  assign inv_src1 = ~i_src1;

  bssu_msb_find u_scan (
    .i_word(i_src1),
    .o_found(scan_found),
    .o_index(scan_idx)
  );

  bssu_msb_find u_span (
    .i_word(inv_src1),
    .o_found(span_found),
    .o_index(span_idx)
  );

  wire logic [31:0] scan_dst;
  wire logic [2:0] scan_cc;
  wire logic [31:0] span_dst;
  wire logic [2:0] span_cc;
  assign scan_dst = scan_found ? {27'h0, scan_idx} : bssu_pkg::ALL_ONES;
  assign scan_cc = scan_found ? bssu_pkg::CC_FOUND : bssu_pkg::CC_NONE;
  assign span_dst = span_found ? {27'h0, span_idx} : bssu_pkg::ALL_ONES;
  assign span_cc = span_found ? bssu_pkg::CC_FOUND : bssu_pkg::CC_NONE;

  // ---------------------------------------------------------------
  // Byte lane equality
  // ---------------------------------------------------------------
  wire logic [3:0] lane_eq;
  wire logic byte_hit;
  for (genvar l = 0; l < bssu_pkg::LANES; l++) begin : g_lane
    assign lane_eq[l] = (i_src1[l*bssu_pkg::LANE_W +: bssu_pkg::LANE_W]
                         == i_src2[l*bssu_pkg::LANE_W +: bssu_pkg::LANE_W]);
  end
  assign byte_hit = |lane_eq;
  wire logic [2:0] byte_cc;
  assign byte_cc = byte_hit ? bssu_pkg::CC_FOUND : bssu_pkg::CC_NONE;

  // ---------------------------------------------------------------
  // Select and bit set
  // ---------------------------------------------------------------
  wire logic sel_take2;
  wire logic [31:0] sel_dst;
  wire logic [31:0] setbit_dst;
  wire logic sel_unordered;
  wire logic sel_code_zero;
  wire logic sel_mask_hit;
  assign sel_unordered = (i_sel_mask == bssu_pkg::MASK_UNORDERED);
  assign sel_code_zero = (i_condition_code_field == bssu_pkg::CC_NONE);
  assign sel_mask_hit = |(i_sel_mask & i_condition_code_field);
  assign sel_take2 = (sel_unordered && sel_code_zero) || sel_mask_hit;
  assign sel_dst = sel_take2 ? i_src2 : i_src1;
  assign setbit_dst = i_src2 | (32'h00000001 << i_src1[4:0]);

  // ---------------------------------------------------------------
  // Shifts
  // ---------------------------------------------------------------
  wire logic [5:0] count;
  wire logic big_count;
  assign big_count = (i_src1 >= 32'h00000020);
  assign count = big_count ? bssu_pkg::MAX_SHIFT : {1'b0, i_src1[4:0]};

  wire logic [31:0] shl_dst;
  wire logic [31:0] shr_dst;
  assign shl_dst = big_count ? bssu_pkg::ZERO_WORD : (i_src2 << count[4:0]);
  assign shr_dst = big_count ? bssu_pkg::ZERO_WORD : (i_src2 >> count[4:0]);

  // ---------------------------------------------------------------
  // Arithmetic right: sign replicated; count 32 leaves all sign bits
  // ---------------------------------------------------------------
  wire logic [31:0] sar_dst;
  wire logic [63:0] sar_wide;
  assign sar_wide = {{32{i_src2[31]}}, i_src2} >> count;
  assign sar_dst = sar_wide[31:0];

  // ---------------------------------------------------------------
  // Dividing right: round up when negative bits are lost
  // ---------------------------------------------------------------
  logic [31:0] lost_mask;
  always_comb begin
    lost_mask = big_count ? bssu_pkg::ALL_ONES
                          : ((32'h00000001 << count[4:0]) - 32'h00000001);
  end
  wire logic lost_nz;
  wire logic [31:0] div_dst;
  assign lost_nz = |(i_src2 & lost_mask);
  wire logic div_round;
  assign div_round = i_src2[31] && lost_nz;
  assign div_dst = sar_dst + {31'h0, div_round};

  // ---------------------------------------------------------------
  // Arithmetic left: headroom before a bit unlike bit 31 reaches it
  // ---------------------------------------------------------------
  wire logic [31:0] sign_diff;
  wire logic diff_found;
  wire logic [4:0] diff_idx;
  wire logic [5:0] diff_gap;
  wire logic [5:0] safe_steps;
  assign sign_diff = i_src2 ^ {32{i_src2[31]}};

  bssu_msb_find u_headroom (
    .i_word(sign_diff),
    .o_found(diff_found),
    .o_index(diff_idx)
  );

  // Zero and all-ones sources never run out of headroom
  assign diff_gap = 6'(bssu_pkg::MSB) - 6'h01 - {1'b0, diff_idx};
  assign safe_steps = diff_found ? diff_gap : bssu_pkg::MAX_SHIFT;
  wire logic sal_ovf;
  wire logic [5:0] sal_steps;
  wire logic [31:0] sal_dst;
  assign sal_ovf = (count > safe_steps) && (i_src2 != bssu_pkg::ZERO_WORD);
  assign sal_steps = sal_ovf ? safe_steps : count;
  assign sal_dst = (sal_steps >= bssu_pkg::MAX_SHIFT) ? bssu_pkg::ZERO_WORD
                                                      : (i_src2 << sal_steps[4:0]);

  // ---------------------------------------------------------------
  // Result selection
  // ---------------------------------------------------------------
  logic [31:0] next_dst;
  logic next_dst_we;
  logic [2:0] next_cc;
  logic next_cc_we;
  logic next_ovf_set;
  logic next_fault;
  always_comb begin
    next_dst = bssu_pkg::ZERO_WORD;
    next_dst_we = 1'b0;
    next_cc = i_condition_code_field;
    next_cc_we = 1'b0;
    next_ovf_set = 1'b0;
    next_fault = 1'b0;
    if (i_issue) begin
      unique case (i_op)
        bssu_pkg::OP_SCAN_SET: begin
          next_dst = scan_dst;
          next_dst_we = 1'b1;
          next_cc = scan_cc;
          next_cc_we = 1'b1;
        end
        bssu_pkg::OP_SPAN_CLR: begin
          next_dst = span_dst;
          next_dst_we = 1'b1;
          next_cc = span_cc;
          next_cc_we = 1'b1;
        end
        bssu_pkg::OP_SCAN_BYTE: begin
          next_cc = byte_cc;
          next_cc_we = 1'b1;
        end
        bssu_pkg::OP_SELECT: begin
          next_dst = sel_dst;
          next_dst_we = 1'b1;
        end
        bssu_pkg::OP_SET_BIT: begin
          next_dst = setbit_dst;
          next_dst_we = 1'b1;
        end
        bssu_pkg::OP_SHL_LOG: begin
          next_dst = shl_dst;
          next_dst_we = 1'b1;
        end
        bssu_pkg::OP_SHR_LOG: begin
          next_dst = shr_dst;
          next_dst_we = 1'b1;
        end
        bssu_pkg::OP_SHL_ARI: begin
          next_dst = sal_dst;
          next_dst_we = 1'b1;
          next_ovf_set = sal_ovf && i_overflow_mask_flag;
          next_fault = sal_ovf && !i_overflow_mask_flag;
        end
        bssu_pkg::OP_SHR_ARI: begin
          next_dst = sar_dst;
          next_dst_we = 1'b1;
        end
        bssu_pkg::OP_SHR_DIV: begin
          next_dst = div_dst;
          next_dst_we = 1'b1;
        end
        default: begin
          next_dst = bssu_pkg::ZERO_WORD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Handshake registers, loaded on the edge after issue
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
    end else begin
      o_done <= i_issue;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dst_we <= 1'b0;
    end else begin
      o_dst_we <= next_dst_we;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cc_we <= 1'b0;
    end else begin
      o_cc_we <= next_cc_we;
    end
  end

  // ---------------------------------------------------------------
  // Result registers, loaded on the same edge as o_done
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dst <= bssu_pkg::ZERO_WORD;
    end else begin
      o_dst <= next_dst;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_condition_code_field <= bssu_pkg::CC_NONE;
    end else begin
      o_condition_code_field <= next_cc;
    end
  end

  // ---------------------------------------------------------------
  // Overflow registers
  // ---------------------------------------------------------------
  // Sticky flag is only ever set here; the core owns its clearing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overflow_sticky_flag <= 1'b0;
    end else begin
      o_overflow_sticky_flag <= i_overflow_sticky_flag | next_ovf_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overflow_fault <= 1'b0;
    end else begin
      o_overflow_fault <= next_fault;
    end
  end

endmodule : bssu_unit

// ### design/bssu_pkg.sv
/*
  Shared constants for the bit scan, select and shift unit.
  Assumes a single core clock domain and a decoder that issues one operation at a time.
*/
package bssu_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned CC_W = 3;
  localparam int unsigned OP_W = 4;
  localparam int unsigned CNT_W = 32;

  // Operation codes seen on the issue port
  localparam logic [3:0] OP_SCAN_SET = 4'h0;
  localparam logic [3:0] OP_SPAN_CLR = 4'h1;
  localparam logic [3:0] OP_SCAN_BYTE = 4'h2;
  localparam logic [3:0] OP_SELECT = 4'h3;
  localparam logic [3:0] OP_SET_BIT = 4'h4;
  localparam logic [3:0] OP_SHL_LOG = 4'h5;
  localparam logic [3:0] OP_SHR_LOG = 4'h6;
  localparam logic [3:0] OP_SHL_ARI = 4'h7;
  localparam logic [3:0] OP_SHR_ARI = 4'h8;
  localparam logic [3:0] OP_SHR_DIV = 4'h9;

  // Condition code values
  localparam logic [2:0] CC_FOUND = 3'h2;
  localparam logic [2:0] CC_NONE = 3'h0;

  // Select masks
  localparam logic [2:0] MASK_UNORDERED = 3'h0;
  localparam logic [2:0] MASK_GREATER = 3'h1;
  localparam logic [2:0] MASK_EQUAL = 3'h2;
  localparam logic [2:0] MASK_GE = 3'h3;
  localparam logic [2:0] MASK_LESS = 3'h4;
  localparam logic [2:0] MASK_NE = 3'h5;
  localparam logic [2:0] MASK_LE = 3'h6;
  localparam logic [2:0] MASK_ORDERED = 3'h7;

  localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [5:0] MAX_SHIFT = 6'h20;
  localparam int unsigned MSB = 31;
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_W = 8;

endpackage : bssu_pkg

// ### design/bssu_msb_find.sv
/*
  Highest set bit finder for one 32-bit word.
  Assumes nothing beyond a purely combinational context.
*/
module bssu_msb_find (
  input wire logic [31:0] i_word,
  output logic o_found,
  output logic [4:0] o_index
);

  always_comb begin
    o_found = 1'b0;
    o_index = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (i_word[i]) begin
        o_found = 1'b1;
        o_index = 5'(i);
      end
    end
  end

endmodule : bssu_msb_find

// ### verification/bssu_unit_properties.sv
/* Port checker for bssu_unit.
   Assumes one clock and an asynchronous active-low reset. */
module bssu_unit_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_issue,
  input wire logic [3:0] i_op,
  input wire logic [31:0] i_src1,
  input wire logic [31:0] i_src2,
  input wire logic [2:0] i_sel_mask,
  input wire logic [2:0] i_condition_code_field,
  input wire logic i_overflow_mask_flag,
  input wire logic o_done,
  input wire logic [31:0] o_dst,
  input wire logic o_dst_we,
  input wire logic [2:0] o_condition_code_field,
  input wire logic o_cc_we,
  input wire logic o_overflow_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire logic lane_eq = (i_src1[7:0] == i_src2[7:0]) || (i_src1[15:8] == i_src2[15:8]) ||
    (i_src1[23:16] == i_src2[23:16]) || (i_src1[31:24] == i_src2[31:24]);
  wire logic take2 = (i_sel_mask == 3'h0 && i_condition_code_field == 3'h0) ||
    ((i_sel_mask & i_condition_code_field) != 3'h0);
  wire logic [3:0] op = i_issue ? i_op : 4'hF;
  done_tracks_issue_a: assert property (o_done == $past(i_issue))
    else $error("done not one cycle after issue");
  scan_index_a: assert property (op == bssu_pkg::OP_SCAN_SET && i_src1 != 0 |=> o_cc_we &&
    o_condition_code_field == bssu_pkg::CC_FOUND && ($past(i_src1) >> o_dst) == 32'h1)
    else $error("set scan result wrong");
  scan_zero_a: assert property (op == bssu_pkg::OP_SCAN_SET && i_src1 == 0 |=>
    o_dst == bssu_pkg::ALL_ONES && o_condition_code_field == bssu_pkg::CC_NONE)
    else $error("zero scan result wrong");
  span_ones_a: assert property (op == bssu_pkg::OP_SPAN_CLR && i_src1 == 32'hFFFFFFFF |=>
    o_dst == bssu_pkg::ALL_ONES && o_condition_code_field == bssu_pkg::CC_NONE)
    else $error("all ones span result wrong");
  byte_code_a: assert property (op == bssu_pkg::OP_SCAN_BYTE |=> !o_dst_we && o_cc_we &&
    o_condition_code_field == ($past(lane_eq) ? bssu_pkg::CC_FOUND : bssu_pkg::CC_NONE))
    else $error("byte scan code wrong");
  select_pick_a: assert property (op == bssu_pkg::OP_SELECT |=>
    o_dst == ($past(take2) ? $past(i_src2) : $past(i_src1)))
    else $error("select picked wrong source");
  set_bit_a: assert property (op == bssu_pkg::OP_SET_BIT |=>
    o_dst == ($past(i_src2) | (32'h1 << $past(i_src1[4:0]))))
    else $error("bit set result wrong");
  shift_sat_a: assert property (op == bssu_pkg::OP_SHR_ARI && i_src1 > 32 |=>
    o_dst == {32{$past(i_src2[31])}})
    else $error("saturated right shift wrong");
  fault_cause_a: assert property (o_overflow_fault |->
    $past(op) == bssu_pkg::OP_SHL_ARI && !$past(i_overflow_mask_flag))
    else $error("fault without masked-off left shift");
  cover property (op == bssu_pkg::OP_SELECT && take2);
  cover property (o_overflow_fault);
  cover property (op == bssu_pkg::OP_SCAN_BYTE && lane_eq);
endmodule : bssu_unit_chk

bind bssu_unit bssu_unit_chk i_bssu_unit_chk (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_issue(i_issue),
  .i_op(i_op),
  .i_src1(i_src1),
  .i_src2(i_src2),
  .i_sel_mask(i_sel_mask),
  .i_condition_code_field(i_condition_code_field),
  .i_overflow_mask_flag(i_overflow_mask_flag),
  .o_done(o_done),
  .o_dst(o_dst),
  .o_dst_we(o_dst_we),
  .o_condition_code_field(o_condition_code_field),
  .o_cc_we(o_cc_we),
  .o_overflow_fault(o_overflow_fault)
);

// ### verification/bssu_core_model.sv
/* Core side model: condition code and sticky overflow registers.
   Assumes updates arrive as the unit's registered write pulses. */
module bssu_core_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cc_we,
  input wire logic [2:0] i_cc,
  input wire logic i_done,
  input wire logic i_sticky,
  input wire logic i_load,
  input wire logic [2:0] i_load_cc,
  output logic [2:0] o_cc,
  output logic o_sticky
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cc <= 3'h0;
      o_sticky <= 1'b0;
    end else if (i_load) begin
      o_cc <= i_load_cc;
      o_sticky <= 1'b0;
    end else begin
      if (i_cc_we) o_cc <= i_cc;
      if (i_done) o_sticky <= i_sticky;
    end
  end
endmodule : bssu_core_model

// ### verification/tb_top.sv
/* Bench for bssu_unit with a core-side model.
   Assumes one-cycle answers; inputs change 1 ns after the rising edge. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_n, i_issue, i_overflow_mask_flag, i_overflow_sticky_flag, load;
  logic o_done, o_dst_we, o_cc_we, o_overflow_sticky_flag, o_overflow_fault;
  logic [3:0] i_op;
  logic [31:0] i_src1, i_src2, o_dst;
  logic [2:0] i_sel_mask, i_condition_code_field, o_condition_code_field, load_cc;
  int n_fail, checks, cyc;
  bssu_unit i_bssu_unit (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_issue(i_issue),
    .i_op(i_op),
    .i_src1(i_src1),
    .i_src2(i_src2),
    .i_sel_mask(i_sel_mask),
    .i_condition_code_field(i_condition_code_field),
    .i_overflow_mask_flag(i_overflow_mask_flag),
    .i_overflow_sticky_flag(i_overflow_sticky_flag),
    .o_done(o_done),
    .o_dst(o_dst),
    .o_dst_we(o_dst_we),
    .o_condition_code_field(o_condition_code_field),
    .o_cc_we(o_cc_we),
    .o_overflow_sticky_flag(o_overflow_sticky_flag),
    .o_overflow_fault(o_overflow_fault)
  );
  bssu_core_model i_bssu_core_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cc_we(o_cc_we),
    .i_cc(o_condition_code_field), .i_done(o_done), .i_sticky(o_overflow_sticky_flag),
    .i_load(load), .i_load_cc(load_cc), .o_cc(i_condition_code_field),
    .o_sticky(i_overflow_sticky_flag));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] msb(input logic [31:0] w);
    msb = 32'hFFFFFFFF;
    for (int i = 0; i < 32; i++) if (w[i]) msb = 32'(i);
  endfunction : msb
  task automatic run(input logic [3:0] o, input logic [31:0] a, input logic [31:0] b,
      input logic [2:0] m);
    i_issue = 1'b1;
    i_op = o;
    i_src1 = a;
    i_src2 = b;
    i_sel_mask = m;
    @(posedge i_clk) #1;
    chk(o_done, 1'b1);
  endtask : run
  task automatic idle;
    i_issue = 1'b0;
    @(posedge i_clk) #1;
    chk(o_done, 1'b0);
  endtask : idle
  task automatic t_scan;
    logic [31:0] v [4] = '{32'h0, 32'h1, 32'h00000100, 32'h80000001};
    for (int k = 0; k < 4; k++) begin
      run(bssu_pkg::OP_SCAN_SET, v[k], 32'h0, 3'h0);
      chk(o_dst, msb(v[k]));
      chk(o_condition_code_field, v[k] != 0 ? 3'h2 : 3'h0);
      run(bssu_pkg::OP_SPAN_CLR, ~v[k], 32'h0, 3'h0);
      chk(o_dst, msb(v[k]));
      chk(o_condition_code_field, v[k] != 0 ? 3'h2 : 3'h0);
      chk(o_cc_we, 1'b1);
    end
    idle();
  endtask : t_scan
  task automatic t_byte;
    logic [31:0] a [3] = '{32'h00AB0011, 32'h01020304, 32'hAA000000};
    logic [31:0] b [3] = '{32'h11AB1100, 32'h10203040, 32'hAA111111};
    logic [2:0] e [3] = '{3'h2, 3'h0, 3'h2};
    for (int k = 0; k < 3; k++) begin
      run(bssu_pkg::OP_SCAN_BYTE, a[k], b[k], 3'h0);
      chk(o_condition_code_field, e[k]);
      chk(o_dst_we, 1'b0);
    end
    idle();
  endtask : t_byte
  task automatic t_select;
    for (int m = 0; m < 8; m++) begin
      for (int c = 0; c < 8; c++) begin
        load = 1'b1;
        load_cc = 3'(c);
        @(posedge i_clk) #1;
        load = 1'b0;
        run(bssu_pkg::OP_SELECT, 32'h11111111, 32'h22222222, 3'(m));
        chk(o_dst, ((m == 0 && c == 0) || (m & c) != 0) ? 32'h22222222 : 32'h11111111);
      end
    end
    idle();
  endtask : t_select
  task automatic t_shift;
    logic [3:0] o [12] = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h6, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9};
    logic [31:0] a [12] = '{15, 63, 32, 4, 32, 40, 4, 4, 40, 1, 40, 2};
    logic [31:0] b [12] = '{0, 1, 32'h80000000, 32'h12345678, 32'hFFFFFFFF, 32'hFFFFFFFF,
      32'h80000000, 32'h80000000, 32'h80000000, 32'hFFFFFFF9, 32'h80000000, 7};
    logic [31:0] e [12] = '{32'h8000, 32'h80000001, 32'h80000001, 32'h23456780, 0, 0,
      32'h08000000, 32'hF8000000, 32'hFFFFFFFF, 32'hFFFFFFFD, 0, 1};
    for (int k = 0; k < 12; k++) begin
      run(o[k], a[k], b[k], 3'h0);
      chk(o_dst, e[k]);
    end
    idle();
  endtask : t_shift
  task automatic t_ovf;
    load = 1'b1;
    load_cc = 3'h0;
    i_overflow_mask_flag = 1'b1;
    @(posedge i_clk) #1;
    load = 1'b0;
    run(bssu_pkg::OP_SHL_ARI, 4, 32'h10000000, 3'h0);
    chk(o_dst, 32'h40000000);
    chk({o_overflow_sticky_flag, o_overflow_fault}, 2'b10);
    run(bssu_pkg::OP_SHL_ARI, 4, 32'h1, 3'h0);
    chk(o_dst, 32'h00000010);
    chk(o_overflow_fault, 1'b0);
    i_overflow_mask_flag = 1'b0;
    run(bssu_pkg::OP_SHL_ARI, 4, 32'h10000000, 3'h0);
    chk(o_dst, 32'h40000000);
    chk(o_overflow_fault, 1'b1);
    idle();
  endtask : t_ovf
  task automatic t_refused;
    run(4'hC, 32'h00000100, 32'h00000002, 3'h0);
    chk(o_dst_we, 1'b0);
    chk(o_cc_we, 1'b0);
    idle();
  endtask : t_refused
  task automatic t_reset;
    run(bssu_pkg::OP_SCAN_SET, 32'h00000100, 32'h0, 3'h0);
    i_issue = 1'b0;
    i_rst_n = 1'b0;
    @(posedge i_clk) #1;
    chk({o_done, o_dst_we, o_cc_we, o_overflow_sticky_flag, o_overflow_fault}, 5'h00);
    chk(o_dst, 32'h0);
    chk(o_condition_code_field, 3'h0);
    i_rst_n = 1'b1;
    run(bssu_pkg::OP_SCAN_SET, 32'h00000100, 32'h0, 3'h0);
    chk(o_dst, 32'h00000008);
    chk(o_condition_code_field, 3'h2);
    idle();
  endtask : t_reset
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    i_rst_n = 1'b0;
    i_issue = 1'b0;
    i_op = 4'h0;
    i_src1 = 32'h0;
    i_src2 = 32'h0;
    i_sel_mask = 3'h0;
    i_overflow_mask_flag = 1'b0;
    load = 1'b0;
    load_cc = 3'h0;
    repeat (20) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    t_scan();
    t_byte();
    t_select();
    t_shift();
    t_ovf();
    t_refused();
    t_reset();
    report_and_stop();
  end
endmodule : tb_top
